// *** design/rstc_pkg.sv ***
// Constants for the radio state transition configuration block
// Contract
// (RULE1) Two-bit clear channel policy selects indication
// (RULE2) Clear channel flag follows policy, reset 11
// (RULE3) Post-receive next state from two-bit field
// (RULE4) Post-transmit next state from two-bit field
// (RULE5) Calibration policy 00: never calibrate automatically
// (RULE6) Policy 01: calibrate leaving idle
// (RULE7) Policy 10: calibrate on automatic idle return
// (RULE8) Policy 11: calibrate every fourth return
// (RULE9) Modulo-four counter of returns, calibrate on wrap
// (RULE10) Carrier timeout: OOK needs carrier in 8 symbols
package rstc_pkg;
    localparam logic [7:0] RSTC_ADDR_RXTO   = 8'h16;
    localparam logic [7:0] RSTC_ADDR_STC    = 8'h17;
    localparam logic [7:0] RSTC_ADDR_CALCFG = 8'h18;
    localparam int         RSTC_TO_BIT      = 4;
    localparam logic [3:0] RSTC_TO_LOW_RST  = 4'h7;
    localparam logic [5:0] RSTC_STC_RST     = 6'h30;
    localparam logic [1:0] RSTC_CAL_RST     = 2'h0;
    localparam int         RSTC_CCA_LSB     = 4;
    localparam int         RSTC_RXO_LSB     = 2;
    localparam int         RSTC_CAL_LSB     = 4;
    localparam logic [3:0] RSTC_OOK_SYMBOLS = 4'h8;
    typedef enum logic [3:0] {
        RSTC_ST_IDLE  = 4'h1,
        RSTC_ST_SYNTH = 4'h2,
        RSTC_ST_TX    = 4'h4,
        RSTC_ST_RX    = 4'h8
    } rstc_state_t;
endpackage

// *** design/rstc_top.sv ***
// Radio state transition configuration: registers, policy decode, calibration
`timescale 1ns/10ps
module rstc_top
    import rstc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic [7:0]  rd_addr,
    output logic      [7:0]  rd_data,
    input  wire logic        rssi_below,
    input  wire logic        pkt_receiving,
    input  wire logic        rx_done,
    input  wire logic        tx_done,
    input  wire logic        leave_idle,
    input  wire logic        auto_idle,
    input  wire logic        ook_mode,
    input  wire logic        symbol_tick,
    input  wire logic        carrier_sense,
    input  wire logic        rx_start,
    output logic             clear_channel_flag,
    output rstc_state_t      post_receive_state,
    output rstc_state_t      post_transmit_state,
    output logic             calibrate_pulse,
    output logic             rx_timeout
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [3:0] to_low_r;
    logic       to_en_r;
    logic [1:0] cca_r;
    logic [1:0] rxo_r;
    logic [1:0] txo_r;
    logic [1:0] cal_r;
    logic [1:0] ret_cnt_r;
    logic [3:0] sym_cnt_r;
    logic       rx_watch_r;

    function automatic rstc_state_t next_st(input logic [1:0] sel, input logic is_rx);
        case (sel)
            2'h0:    next_st = RSTC_ST_IDLE;
            2'h1:    next_st = RSTC_ST_SYNTH;
            2'h2:    next_st = RSTC_ST_TX;
            2'h3:    next_st = is_rx ? RSTC_ST_RX : RSTC_ST_RX;
            default: next_st = RSTC_ST_IDLE;
        endcase
    endfunction

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            to_low_r <= RSTC_TO_LOW_RST;
            to_en_r  <= 1'b0;
            {cca_r, rxo_r, txo_r} <= RSTC_STC_RST; // RULE2
            cal_r    <= RSTC_CAL_RST; // RULE5
        end
        else if (wr_en)
        begin
            case (wr_addr)
                RSTC_ADDR_RXTO:
                begin
                    to_en_r  <= wr_data[RSTC_TO_BIT];
                    to_low_r <= wr_data[3:0];
                end
                RSTC_ADDR_STC:
                begin
                    cca_r <= wr_data[RSTC_CCA_LSB+:2];
                    rxo_r <= wr_data[RSTC_RXO_LSB+:2];
                    txo_r <= wr_data[1:0];
                end
                RSTC_ADDR_CALCFG: cal_r <= wr_data[RSTC_CAL_LSB+:2];
                default: ;
            endcase
        end
    end

    always_comb
    begin
        case (rd_addr)
            RSTC_ADDR_RXTO:   rd_data = {3'h0, to_en_r, to_low_r};
            RSTC_ADDR_STC:    rd_data = {2'h0, cca_r, rxo_r, txo_r};
            RSTC_ADDR_CALCFG: rd_data = {2'h0, cal_r, 4'h0};
            default:          rd_data = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Clear channel and next states
    // ----------------------------------------
    // Registered, so the flag trails its inputs by one clock
    always_ff @(posedge clk)
    begin
        if (srst)
            clear_channel_flag <= 1'b0;
        else
            case (cca_r) // RULE1
                2'h0:    clear_channel_flag <= 1'b1;
                2'h1:    clear_channel_flag <= rssi_below;
                2'h2:    clear_channel_flag <= !pkt_receiving;
                default: clear_channel_flag <= rssi_below && !pkt_receiving;
            endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            post_receive_state  <= RSTC_ST_IDLE;
            post_transmit_state <= RSTC_ST_IDLE;
        end
        else
        begin
            if (rx_done)
                post_receive_state <= next_st(rxo_r, 1'b1); // RULE3
            if (tx_done)
                post_transmit_state <= next_st(txo_r, 1'b0); // RULE4
        end
    end

    // ----------------------------------------
    // Automatic calibration
    // ----------------------------------------
    // Count survives policy changes; switching away and back resumes mid-cycle
    always_ff @(posedge clk)
    begin
        if (srst)
            ret_cnt_r <= 2'h0;
        else if (auto_idle && cal_r == 2'h3)
            ret_cnt_r <= ret_cnt_r + 2'h1; // RULE9
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            calibrate_pulse <= 1'b0;
        else
            case (cal_r)
                2'h1:    calibrate_pulse <= leave_idle; // RULE6
                2'h2:    calibrate_pulse <= auto_idle; // RULE7
                2'h3:    calibrate_pulse <= auto_idle && ret_cnt_r == 2'h3; // RULE8
                default: calibrate_pulse <= 1'b0; // RULE5
            endcase
    end

    // ----------------------------------------
    // Carrier timeout
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rx_watch_r <= 1'b0;
            sym_cnt_r  <= 4'h0;
            rx_timeout <= 1'b0;
        end
        else
        begin
            rx_timeout <= 1'b0;
            // Restart wins over carrier in the same cycle; one carrier hit disarms
            if (rx_start)
            begin
                rx_watch_r <= to_en_r && ook_mode;
                sym_cnt_r  <= 4'h0;
            end
            else if (rx_watch_r)
            begin
                if (carrier_sense)
                    rx_watch_r <= 1'b0;
                else if (symbol_tick)
                begin
                    sym_cnt_r <= sym_cnt_r + 4'h1;
                    if (sym_cnt_r + 4'h1 == RSTC_OOK_SYMBOLS)
                    begin
                        rx_timeout <= 1'b1; // RULE10
                        rx_watch_r <= 1'b0;
                    end
                end
            end
        end
    end

    AST_CCA_ALWAYS: assert property (@(posedge clk) disable iff (srst) // RULE1
        $past(cca_r) == 2'h0 && !$past(srst) |-> clear_channel_flag)
        else $error("clear flag low under always-clear policy");
    AST_CCA_RSSI: assert property (@(posedge clk) disable iff (srst) // RULE1
        $past(cca_r) == 2'h1 && !$past(srst) |-> clear_channel_flag == $past(rssi_below))
        else $error("clear flag does not follow signal level");
    AST_CCA_BOTH: assert property (@(posedge clk) disable iff (srst) // RULE2
        $past(cca_r) == 2'h3 && $past(pkt_receiving) && !$past(srst) |-> !clear_channel_flag)
        else $error("clear flag high while receiving");
    AST_RXO_TX: assert property (@(posedge clk) disable iff (srst) // RULE3
        rx_done && rxo_r == 2'h2 |=> post_receive_state == RSTC_ST_TX)
        else $error("wrong post-receive state");
    AST_TXO_RX: assert property (@(posedge clk) disable iff (srst) // RULE4
        tx_done && txo_r == 2'h3 |=> post_transmit_state == RSTC_ST_RX)
        else $error("wrong post-transmit state");
    AST_CAL_NEVER: assert property (@(posedge clk) disable iff (srst) // RULE5
        $past(cal_r) == 2'h0 && !$past(srst) |-> !calibrate_pulse)
        else $error("calibration with policy zero");
    AST_CAL_LEAVE: assert property (@(posedge clk) disable iff (srst) // RULE6
        cal_r == 2'h1 && leave_idle |=> calibrate_pulse)
        else $error("missed calibration leaving idle");
    AST_CAL_RET: assert property (@(posedge clk) disable iff (srst) // RULE7
        cal_r == 2'h2 && auto_idle |=> calibrate_pulse)
        else $error("missed calibration on idle return");
    AST_CAL_FOURTH: assert property (@(posedge clk) disable iff (srst) // RULE8
        cal_r == 2'h3 && auto_idle && ret_cnt_r != 2'h3 |=> !calibrate_pulse)
        else $error("calibration before fourth return");
    AST_CAL_HIT: assert property (@(posedge clk) disable iff (srst) // RULE8
        cal_r == 2'h3 && auto_idle && ret_cnt_r == 2'h3 |=> calibrate_pulse)
        else $error("missed calibration on fourth return");
    AST_CNT_WRAP: assert property (@(posedge clk) disable iff (srst) // RULE9
        cal_r == 2'h3 && auto_idle |=> ret_cnt_r == $past(ret_cnt_r) + 2'h1)
        else $error("return counter did not advance");
    AST_TO_CARRIER: assert property (@(posedge clk) disable iff (srst) // RULE10
        carrier_sense && !rx_start |=> !rx_timeout)
        else $error("timeout despite carrier");
    AST_TO_EXPIRE: assert property (@(posedge clk) disable iff (srst) // RULE10
        rx_watch_r && !rx_start && !carrier_sense && symbol_tick
            && sym_cnt_r == RSTC_OOK_SYMBOLS - 4'h1 |=> rx_timeout)
        else $error("no timeout after last silent symbol");
endmodule

// *** verification/rstc_host.sv ***
// Host model: register writes and reads
`timescale 1ns/10ps
module rstc_host (
    input  wire logic       clk,
    output logic            wr_en,
    output logic      [7:0] wr_addr,
    output logic      [7:0] wr_data,
    output logic      [7:0] rd_addr,
    input  wire logic [7:0] rd_data
);
    initial
    begin
        wr_en = 1'b0;
        {wr_addr, wr_data, rd_addr} = 24'h000000;
    end
    // Policy 00 leaves calibration to the host
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        {wr_addr, wr_data} <= {a, d};
        @(posedge clk);
        wr_en <= 1'b0;
        wr_data <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_addr <= a;
        @(posedge clk);
        d = rd_data;
    endtask
endmodule

// *** verification/rstc_top_test.sv ***
// Self-checking bench for the state transition configuration
`timescale 1ns/10ps
module rstc_top_test;
    import rstc_pkg::*;
    logic clk, srst, wr_en, rssi_below, pkt_receiving, ook_mode, carrier_sense;
    logic rx_done, tx_done, leave_idle, auto_idle, symbol_tick, rx_start;
    logic clear_channel_flag, calibrate_pulse, rx_timeout;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data, v;
    logic [1:0] m;
    rstc_state_t post_receive_state, post_transmit_state;
    int mismatches = 0, checked = 0, cal_n = 0, tmo_n = 0, c0;
    logic [31:0] seed = 32'h00009A1F;
    rstc_host u_rstc_host (
        .clk     (clk),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );
    rstc_top u_rstc_top (
        .clk                 (clk),
        .srst                (srst),
        .wr_en               (wr_en),
        .wr_addr             (wr_addr),
        .wr_data             (wr_data),
        .rd_addr             (rd_addr),
        .rd_data             (rd_data),
        .rssi_below          (rssi_below),
        .pkt_receiving       (pkt_receiving),
        .rx_done             (rx_done),
        .tx_done             (tx_done),
        .leave_idle          (leave_idle),
        .auto_idle           (auto_idle),
        .ook_mode            (ook_mode),
        .symbol_tick         (symbol_tick),
        .carrier_sense       (carrier_sense),
        .rx_start            (rx_start),
        .clear_channel_flag  (clear_channel_flag),
        .post_receive_state  (post_receive_state),
        .post_transmit_state (post_transmit_state),
        .calibrate_pulse     (calibrate_pulse),
        .rx_timeout          (rx_timeout)
    );
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] st(input logic [1:0] f);
        case (f)
            2'h0: return 8'(RSTC_ST_IDLE);
            2'h1: return 8'(RSTC_ST_SYNTH);
            2'h2: return 8'(RSTC_ST_TX);
            default: return 8'(RSTC_ST_RX);
        endcase
    endfunction
    function automatic logic exp_cca(input logic [1:0] md, input logic low, input logic busy);
        return (!md[0] || low) && (!md[1] || !busy);
    endfunction
    function automatic logic [7:0] exp_cal(input int pol, input int leaves, input int rets);
        case (pol)
            1: return 8'(leaves);
            2: return 8'(rets);
            3: return 8'(rets / 4);
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic step(input logic [5:0] p);
        @(posedge clk);
        {rx_done, tx_done, leave_idle, auto_idle, rx_start, symbol_tick} <= p;
        @(posedge clk);
        {rx_done, tx_done, leave_idle, auto_idle, rx_start, symbol_tick} <= 6'h00;
    endtask
    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cal_n <= cal_n + int'(calibrate_pulse === 1'b1);
        tmo_n <= tmo_n + int'(rx_timeout === 1'b1);
    end
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        mismatches++;
        finish_test();
    end
    initial
    begin
        srst = 1'b1;
        {rssi_below, pkt_receiving, ook_mode, carrier_sense} = 4'h0;
        {rx_done, tx_done, leave_idle, auto_idle, rx_start, symbol_tick} = 6'h00;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        u_rstc_host.rd(8'h17, v);
        chk("reg17", 8'h30, v);
        u_rstc_host.rd(8'h18, v);
        chk("reg18", 8'h00, v);
        u_rstc_host.rd(8'h5A, v);
        chk("unmapped", 8'h00, v);
        chk("rx_next", st(2'h0), 8'(post_receive_state));
        for (int i = 0; i < 28; i++)
        begin
            seed = xs(seed);
            m = (i < 4) ? 2'(i) : seed[1:0];
            u_rstc_host.wr(8'h17, {2'h3, m, seed[7:4]});
            {rssi_below, pkt_receiving} <= seed[9:8];
            repeat (2) @(posedge clk);
            #1 chk("cca", 8'(exp_cca(m, seed[9], seed[8])), 8'(clear_channel_flag));
        end
        u_rstc_host.rd(8'h17, v);
        chk("reg17 unused", {2'h0, m, seed[7:4]}, v);
        for (int f = 0; f < 4; f++)
        begin
            u_rstc_host.wr(8'h17, 8'((f << 2) | (3 - f)));
            step(6'h30);
            #1 chk("rx_next", st(2'(f)), 8'(post_receive_state));
            chk("tx_next", st(2'(3 - f)), 8'(post_transmit_state));
        end
        for (int p = 0; p < 4; p++)
        begin
            u_rstc_host.wr(8'h18, 8'(p << 4));
            #1 c0 = cal_n;
            repeat (3) step(6'h08);
            repeat (8) step(6'h04);
            repeat (2) @(posedge clk);
            #1 chk("cal count", exp_cal(p, 3, 8), 8'(cal_n - c0));
        end
        u_rstc_host.wr(8'h16, 8'hF7);
        u_rstc_host.rd(8'h16, v);
        chk("reg16", 8'h17, v);
        ook_mode <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            carrier_sense <= (k == 1);
            #1 c0 = tmo_n;
            step(6'h02);
            repeat (8 - int'(k == 2)) step(6'h01);
            repeat (2) @(posedge clk);
            #1 chk("timeout", 8'(k == 0), 8'(tmo_n - c0));
        end
        // Second reset in mid-run: every register back to its reset value
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        u_rstc_host.rd(8'h16, v);
        chk("reg16 reset", 8'h07, v);
        u_rstc_host.rd(8'h17, v);
        chk("reg17 reset", 8'h30, v);
        u_rstc_host.rd(8'h18, v);
        chk("reg18 reset", 8'h00, v);
        chk("rx_next reset", st(2'h0), 8'(post_receive_state));
        finish_test();
    end
endmodule
